// ### design/rsch_top.sv
// Setup command handler, Avalon-MM slave.
// Assumes a master that holds requests while waitrequest is high.
`timescale 1ns/1ps
`include "rsch_cfg.svh"

// What this block does
// - Accepted enter-setup sets acknowledge and in-setup flags.
// - Refused command sets acknowledge and error code.
// - Transmit bit low clears acknowledge.
// - Setup input words: status, channel status 1 and 5, rest zero.
// - Wide values: low half word, then high half word.
// - Channel one command programs channel one, ignores words five to nine.
// - Channel two command programs channel two, ignores words one to four.
// - Both-channel command programs both, checks every data word.
// - Single count 2 to 65536, preset below count.
// - Vendor dual: setup, type, turns, count pair, preset pair, zeros.
// - Vendor dual turns must be listed for the type.
// - Foreign dual: same layout, type 2 to 128.
// - Foreign dual turns must divide the type.
// - Dual count 2 to 65536 times turns, preset below.
// - Setup-data commands only in setup mode.
// - Commands taken only on transmit rising edge.
// - Setup word bits: 0 direction, 1 latch, 8 gearing, rest zero.
// - Save-and-exit saves setup, acknowledges, leaves setup.
// - Plain exit drops edits, acknowledges, resumes with saved set.
module rsch_top
  import rsch_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [`RSCH_AW-1:0] avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  input  wire logic [15:0]        channel_one_status_i,
  input  wire logic [15:0]        channel_two_status_i,
  output rsch_mode_t              mode_o,
  output logic      [15:0]        module_status_o,
  output logic                    nv_save_o,
  output rsch_kind_t              param_kind_o,
  output logic      [15:0]        channel_one_setup_o,
  output logic      [31:0]        channel_one_fsc_o,
  output logic      [31:0]        channel_one_preset_o,
  output logic      [15:0]        channel_two_setup_o,
  output logic      [31:0]        channel_two_fsc_o,
  output logic      [31:0]        channel_two_preset_o,
  output logic      [15:0]        dual_type_o,
  output logic      [15:0]        dual_turns_o
);

  localparam rsch_params_t PARAMS_DEFAULT = '{
    kind:       rsch_kind_single,
    one_setup:  `RSCH_DEF_SETUP,
    one_fsc:    `RSCH_DEF_FSC,
    one_preset: `RSCH_DEF_PRESET,
    two_setup:  `RSCH_DEF_SETUP,
    two_fsc:    `RSCH_DEF_FSC,
    two_preset: `RSCH_DEF_PRESET,
    dual_type:  `RSCH_DEF_TYPE,
    dual_turns: `RSCH_DEF_TURNS
  };

  // Host output words and bus state
  logic [15:0]                  out_word_q [`RSCH_NWORDS];
  logic [15:0]                  out_word_d [`RSCH_NWORDS];
  logic [`RSCH_NWORDS*16-1:0]   words_flat;
  logic                         rd_valid_q;
  logic                         rd_valid_d;
  logic [31:0]                  rdata_q;
  logic [31:0]                  rdata_d;
  logic [3:0]                   idx;
  logic                         region;

  // Command state
  rsch_mode_t                   mode_q;
  rsch_mode_t                   mode_d;
  logic                         ack_q;
  logic                         ack_d;
  logic [3:0]                   err_q;
  logic [3:0]                   err_d;
  logic                         tx_prev_q;
  logic                         tx_prev_d;
  logic                         nv_save_q;
  logic                         nv_save_d;
  rsch_params_t                 edit_q;
  rsch_params_t                 edit_d;
  rsch_params_t                 saved_q;
  rsch_params_t                 saved_d;

  logic                         tx;
  logic                         tx_rise;
  logic [15:0]                  cmd;
  logic                         known;
  logic                         data_ok;
  logic [15:0]                  status;

  // Setup-mode input word
  function automatic logic [15:0] in_word(input logic [3:0] i, input logic [15:0] st,
                                          input logic [15:0] one, input logic [15:0] two);
    logic [15:0] v;
    v = 16'h0000;
    if (i == `RSCH_W_STATUS) begin
      v = st;
    end else if (i == `RSCH_W_ONE_STAT) begin
      v = one;
    end else if (i == `RSCH_W_TWO_STAT) begin
      v = two;
    end
    return v;
  endfunction

  always_comb begin
    for (int i = 0; i < `RSCH_NWORDS; i++) begin
      words_flat[i*16 +: 16] = out_word_q[i];
    end
  end

  rsch_chk u_chk (
    .words_i   (words_flat),
    .known_o   (known),
    .data_ok_o (data_ok)
  );

  assign idx    = avs_address_i[5:2];
  assign region = avs_address_i[`RSCH_REGION_BIT];

  always_comb begin
    status                 = 16'h0000;
    status[`RSCH_ST_ACK]   = ack_q;
    status[`RSCH_ST_SETUP] = (mode_q == rsch_mode_setup);
    status[3:0]            = err_q;
  end

  // Writes land at once, reads answer a cycle later
  assign avs_waitrequest_o = avs_read_i && !rd_valid_q;
  assign avs_readdata_o    = rdata_q;

  always_comb begin
    for (int i = 0; i < `RSCH_NWORDS; i++) begin
      out_word_d[i] = out_word_q[i];
    end
    if (avs_write_i && (region == `RSCH_REGION_OUT) && (idx <= `RSCH_LAST_IDX)) begin
      if (avs_byteenable_i[0]) begin
        out_word_d[idx][7:0] = avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        out_word_d[idx][15:8] = avs_writedata_i[15:8];
      end
    end
    rd_valid_d = avs_read_i && !rd_valid_q;
    rdata_d    = rdata_q;
    if (rd_valid_d) begin
      rdata_d = 32'h00000000;
      if (idx <= `RSCH_LAST_IDX) begin
        if (region == `RSCH_REGION_OUT) begin
          rdata_d = {16'h0000, out_word_q[idx]};
        end else begin
          rdata_d = {16'h0000, in_word(idx, status, channel_one_status_i, channel_two_status_i)};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `RSCH_NWORDS; i++) begin
        out_word_q[i] <= 16'h0000;
      end
      rd_valid_q <= 1'b0;
      rdata_q    <= 32'h00000000;
    end else begin
      for (int i = 0; i < `RSCH_NWORDS; i++) begin
        out_word_q[i] <= out_word_d[i];
      end
      rd_valid_q <= rd_valid_d;
      rdata_q    <= rdata_d;
    end
  end

  assign cmd     = out_word_q[`RSCH_W_CMD];
  assign tx      = cmd[`RSCH_TX_BIT];
  assign tx_rise = tx && !tx_prev_q;

  // Command interpreter
  always_comb begin
    mode_d    = mode_q;
    ack_d     = ack_q;
    err_d     = err_q;
    edit_d    = edit_q;
    saved_d   = saved_q;
    nv_save_d = 1'b0;
    tx_prev_d = tx;
    if (!tx) begin
      ack_d = 1'b0;
    end
    if (tx_rise) begin
      ack_d = 1'b1;
      err_d = `RSCH_ERR_NONE;
      if (cmd == `RSCH_CMD_ENTER) begin
        if ((mode_q != rsch_mode_setup) && (out_word_q[`RSCH_W_PASS] == `RSCH_PASSWORD)) begin
          mode_d = rsch_mode_setup;
        end else begin
          err_d = `RSCH_ERR_CMD;
        end
      end else if (cmd == `RSCH_CMD_SAVE) begin
        if (mode_q == rsch_mode_setup) begin
          saved_d   = edit_q;
          nv_save_d = 1'b1;
          mode_d    = (edit_q.kind == rsch_kind_foreign) ? rsch_mode_align : rsch_mode_meas;
        end else begin
          err_d = `RSCH_ERR_CMD;
        end
      end else if (cmd == `RSCH_CMD_EXIT) begin
        if (mode_q == rsch_mode_setup) begin
          edit_d = saved_q;
          mode_d = rsch_mode_meas;
        end else begin
          err_d = `RSCH_ERR_CMD;
        end
      end else if (known && data_ok && (mode_q == rsch_mode_setup)) begin
        unique case (cmd)
          `RSCH_CMD_SGL_ONE, `RSCH_CMD_SGL_TWO, `RSCH_CMD_SGL_BOTH: begin
            edit_d.kind = rsch_kind_single;
            if (cmd != `RSCH_CMD_SGL_TWO) begin
              edit_d.one_setup  = out_word_q[`RSCH_W_ONE_SETUP];
              edit_d.one_fsc    = join32(out_word_q[`RSCH_W_ONE_FSC_LO], out_word_q[`RSCH_W_ONE_FSC_HI]);
              edit_d.one_preset = {16'h0000, out_word_q[`RSCH_W_ONE_PRESET]};
            end
            if (cmd != `RSCH_CMD_SGL_ONE) begin
              edit_d.two_setup  = out_word_q[`RSCH_W_TWO_SETUP];
              edit_d.two_fsc    = join32(out_word_q[`RSCH_W_TWO_FSC_LO], out_word_q[`RSCH_W_TWO_FSC_HI]);
              edit_d.two_preset = {16'h0000, out_word_q[`RSCH_W_TWO_PRESET]};
            end
          end
          default: begin
            // Dual count and preset live in the channel one slots, dual setup goes to both channels
            edit_d.kind       = (cmd == `RSCH_CMD_FDUAL) ? rsch_kind_foreign : rsch_kind_vendor;
            edit_d.one_setup  = out_word_q[`RSCH_W_D_SETUP];
            edit_d.two_setup  = out_word_q[`RSCH_W_D_SETUP];
            edit_d.dual_type  = out_word_q[`RSCH_W_D_TYPE];
            edit_d.dual_turns = out_word_q[`RSCH_W_D_TURNS];
            edit_d.one_fsc    = join32(out_word_q[`RSCH_W_D_FSC_LO], out_word_q[`RSCH_W_D_FSC_HI]);
            edit_d.one_preset = join32(out_word_q[`RSCH_W_D_PRE_LO], out_word_q[`RSCH_W_D_PRE_HI]);
          end
        endcase
      end else begin
        err_d = `RSCH_ERR_CMD;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q    <= rsch_mode_meas;
      ack_q     <= 1'b0;
      err_q     <= `RSCH_ERR_NONE;
      tx_prev_q <= 1'b0;
      nv_save_q <= 1'b0;
      edit_q    <= PARAMS_DEFAULT;
      saved_q   <= PARAMS_DEFAULT;
    end else begin
      mode_q    <= mode_d;
      ack_q     <= ack_d;
      err_q     <= err_d;
      tx_prev_q <= tx_prev_d;
      nv_save_q <= nv_save_d;
      edit_q    <= edit_d;
      saved_q   <= saved_d;
    end
  end

  assign mode_o               = mode_q;
  assign module_status_o      = status;
  assign nv_save_o            = nv_save_q;
  assign param_kind_o         = saved_q.kind;
  assign channel_one_setup_o  = saved_q.one_setup;
  assign channel_one_fsc_o    = saved_q.one_fsc;
  assign channel_one_preset_o = saved_q.one_preset;
  assign channel_two_setup_o  = saved_q.two_setup;
  assign channel_two_fsc_o    = saved_q.two_fsc;
  assign channel_two_preset_o = saved_q.two_preset;
  assign dual_type_o          = saved_q.dual_type;
  assign dual_turns_o         = saved_q.dual_turns;

endmodule

// ### design/rsch_cfg.svh
// Word positions, codes, limits and defaults of the setup handler.
// Assumes inclusion by bare name.
`ifndef RSCH_CFG_SVH
`define RSCH_CFG_SVH

`define RSCH_NWORDS       10
`define RSCH_LAST_IDX     4'h9
`define RSCH_TX_BIT       15
`define RSCH_ST_ACK       15
`define RSCH_ST_SETUP     12
`define RSCH_ERR_NONE     4'h0
`define RSCH_ERR_CMD      4'h1

`define RSCH_CMD_ENTER    16'hb000
`define RSCH_PASSWORD     16'h1298
`define RSCH_CMD_SGL_ONE  16'hb011
`define RSCH_CMD_SGL_TWO  16'hb021
`define RSCH_CMD_SGL_BOTH 16'hb031
`define RSCH_CMD_VDUAL    16'hb002
`define RSCH_CMD_FDUAL    16'hb004
`define RSCH_CMD_SAVE     16'h800e
`define RSCH_CMD_EXIT     16'h800f

`define RSCH_W_CMD        0
`define RSCH_W_PASS       1
`define RSCH_W_ONE_SETUP  1
`define RSCH_W_ONE_FSC_LO 2
`define RSCH_W_ONE_FSC_HI 3
`define RSCH_W_ONE_PRESET 4
`define RSCH_W_TWO_SETUP  5
`define RSCH_W_TWO_FSC_LO 6
`define RSCH_W_TWO_FSC_HI 7
`define RSCH_W_TWO_PRESET 8
`define RSCH_W_SGL_RSV    9
`define RSCH_W_D_SETUP    1
`define RSCH_W_D_TYPE     2
`define RSCH_W_D_TURNS    3
`define RSCH_W_D_FSC_LO   4
`define RSCH_W_D_FSC_HI   5
`define RSCH_W_D_PRE_LO   6
`define RSCH_W_D_PRE_HI   7
`define RSCH_W_D_RSV_A    8
`define RSCH_W_D_RSV_B    9
`define RSCH_W_ONE_STAT   4'h1
`define RSCH_W_TWO_STAT   4'h5
`define RSCH_W_STATUS     4'h0

`define RSCH_SETUP_MASK   16'h0103
`define RSCH_FSC_MIN      32'h00000002
`define RSCH_FSC_MAX_SGL  32'h00010000
`define RSCH_FTYPE_MIN    16'h0002
`define RSCH_FTYPE_MAX    16'h0080
`define RSCH_VTYPE_A      16'h0064
`define RSCH_VTYPE_B      16'h00b4
`define RSCH_VTYPE_C      16'h03e8
`define RSCH_VTYPE_D      16'h0708
`define RSCH_VTURN_STEP   16'h000a

`define RSCH_DEF_SETUP    16'h0000
`define RSCH_DEF_FSC      32'h00000400
`define RSCH_DEF_PRESET   32'h00000000
`define RSCH_DEF_TYPE     16'h0000
`define RSCH_DEF_TURNS    16'h0001

`define RSCH_AW           7
`define RSCH_REGION_BIT   6
`define RSCH_REGION_OUT   1'b0

`endif

// ### design/rsch_pkg.sv
// Types and helpers of the setup handler.
// Assumes nothing beyond a SystemVerilog compiler.
package rsch_pkg;

  typedef enum logic [1:0] {
    rsch_mode_meas  = 2'b00,
    rsch_mode_setup = 2'b01,
    rsch_mode_align = 2'b11
  } rsch_mode_t;

  typedef enum logic [1:0] {
    rsch_kind_single  = 2'b00,
    rsch_kind_vendor  = 2'b01,
    rsch_kind_foreign = 2'b11
  } rsch_kind_t;

  typedef struct packed {
    rsch_kind_t  kind;
    logic [15:0] one_setup;
    logic [31:0] one_fsc;
    logic [31:0] one_preset;
    logic [15:0] two_setup;
    logic [31:0] two_fsc;
    logic [31:0] two_preset;
    logic [15:0] dual_type;
    logic [15:0] dual_turns;
  } rsch_params_t;

  // Low half word first, high half word second
  function automatic logic [31:0] join32(input logic [15:0] low_half_word, input logic [15:0] high_half_word);
    return {high_half_word, low_half_word};
  endfunction

endpackage

// ### design/rsch_chk.sv
// Range checker for the five setup-data write commands.
// Assumes the host words flattened, word 0 lowest.
`timescale 1ns/1ps
`include "rsch_cfg.svh"
module rsch_chk
  import rsch_pkg::*;
(
  input  wire logic [`RSCH_NWORDS*16-1:0] words_i,
  output logic                            known_o,
  output logic                            data_ok_o
);

  logic [15:0] wd [`RSCH_NWORDS];
  logic [15:0] dtype;
  logic [15:0] turns;
  logic        one_ok;
  logic        two_ok;
  logic        span_dual_ok;
  logic        vturn_ok;
  logic        fturn_ok;

  function automatic logic setup_ok(input logic [15:0] s);
    return (s & ~`RSCH_SETUP_MASK) == 16'h0000;
  endfunction

  // True when b is nonzero and divides a
  function automatic logic divides(input logic [15:0] a, input logic [15:0] b);
    return (b != 16'h0000) && ((a % b) == 16'h0000);
  endfunction

  function automatic logic span_ok(input logic [15:0] s, input logic [31:0] fsc,
                                   input logic [31:0] pre, input logic [31:0] max);
    return setup_ok(s) && (fsc >= `RSCH_FSC_MIN) && (fsc <= max) && (pre < fsc);
  endfunction

  always_comb begin
    for (int i = 0; i < `RSCH_NWORDS; i++) begin
      wd[i] = words_i[i*16 +: 16];
    end
  end

  assign dtype = wd[`RSCH_W_D_TYPE];
  assign turns = wd[`RSCH_W_D_TURNS];

  assign one_ok = span_ok(wd[`RSCH_W_ONE_SETUP], join32(wd[`RSCH_W_ONE_FSC_LO], wd[`RSCH_W_ONE_FSC_HI]),
                          {16'h0000, wd[`RSCH_W_ONE_PRESET]}, `RSCH_FSC_MAX_SGL);
  assign two_ok = span_ok(wd[`RSCH_W_TWO_SETUP], join32(wd[`RSCH_W_TWO_FSC_LO], wd[`RSCH_W_TWO_FSC_HI]),
                          {16'h0000, wd[`RSCH_W_TWO_PRESET]}, `RSCH_FSC_MAX_SGL);

  assign span_dual_ok = span_ok(wd[`RSCH_W_D_SETUP], join32(wd[`RSCH_W_D_FSC_LO], wd[`RSCH_W_D_FSC_HI]),
                                join32(wd[`RSCH_W_D_PRE_LO], wd[`RSCH_W_D_PRE_HI]), {turns, 16'h0000}) &&
                        (wd[`RSCH_W_D_RSV_A] == 16'h0000) && (wd[`RSCH_W_D_RSV_B] == 16'h0000);

  // Larger vendor types only allow tens of turns
  assign vturn_ok = divides(dtype, turns) &&
                    (((dtype == `RSCH_VTYPE_A) || (dtype == `RSCH_VTYPE_B)) ||
                     (((dtype == `RSCH_VTYPE_C) || (dtype == `RSCH_VTYPE_D)) && divides(turns, `RSCH_VTURN_STEP)));

  assign fturn_ok = (dtype >= `RSCH_FTYPE_MIN) && (dtype <= `RSCH_FTYPE_MAX) && divides(dtype, turns);

  always_comb begin
    known_o   = 1'b1;
    data_ok_o = 1'b0;
    unique case (wd[`RSCH_W_CMD])
      `RSCH_CMD_SGL_ONE:  data_ok_o = one_ok;
      `RSCH_CMD_SGL_TWO:  data_ok_o = two_ok && (wd[`RSCH_W_SGL_RSV] == 16'h0000);
      `RSCH_CMD_SGL_BOTH: data_ok_o = one_ok && two_ok && (wd[`RSCH_W_SGL_RSV] == 16'h0000);
      `RSCH_CMD_VDUAL:    data_ok_o = span_dual_ok && vturn_ok;
      `RSCH_CMD_FDUAL:    data_ok_o = span_dual_ok && fturn_ok;
      default:            known_o   = 1'b0;
    endcase
  end

endmodule

// ### verif/rsch_top_properties.sv
// Concurrent checks on the handler ports.
// Assumes a bind onto rsch_top.
`timescale 1ns/1ps
`include "rsch_cfg.svh"
module rsch_top_chk
  import rsch_pkg::*;
(
  input  wire logic [0:0]          clk_i,
  input  wire logic                rst_i,
  input  wire logic [`RSCH_AW-1:0] avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  input  wire logic [31:0]         avs_readdata_o,
  input  wire logic                avs_waitrequest_o,
  input  wire logic [15:0]         channel_one_status_i,
  input  rsch_mode_t               mode_o,
  input  wire logic [15:0]         module_status_o,
  input  wire logic                nv_save_o,
  input  wire logic [31:0]         channel_one_fsc_o,
  input  wire logic [31:0]         channel_one_preset_o
);
  logic       tx_q;
  logic       tx_d;
  logic [3:0] idx;

  assign idx = avs_address_i[5:2];

  // Shadow of the transmit bit as written over the bus
  always_comb begin
    tx_d = tx_q;
    if (avs_write_i && avs_address_i == 7'h00 && avs_byteenable_i[1]) begin
      tx_d = avs_writedata_i[15];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_tx_rise;
    $rose(tx_q);
  endsequence
  sequence s_rd_start;
    avs_read_i && !$past(avs_read_i);
  endsequence
  sequence s_rd_done;
    avs_read_i && !avs_waitrequest_o;
  endsequence

  a_ack_on_rise: assert property (s_tx_rise |=> module_status_o[15])
    else $error("no ack after rise");
  a_ack_clears: assert property ($fell(tx_q) |=> !module_status_o[15])
    else $error("ack not cleared");
  a_ack_needs_rise: assert property ($rose(module_status_o[15]) |-> $past(tx_q) && !$past(tx_q, 2))
    else $error("ack without rise");
  a_held_stable: assert property (tx_q && $past(tx_q) && $past(tx_q, 2) |-> $stable(module_status_o))
    else $error("status moved while held");
  a_status_fields: assert property ((module_status_o & 16'h6ffe) == 16'h0000)
    else $error("illegal status bits");
  a_setup_flag: assert property (module_status_o[12] == (mode_o == rsch_mode_setup))
    else $error("setup flag wrong");
  a_read_wait: assert property (s_rd_start |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read timing");
  a_input_zero: assert property (s_rd_done ##0 (avs_address_i[6] && mode_o == rsch_mode_setup
    && !(idx inside {4'h0, 4'h1, 4'h5})) |-> avs_readdata_o == 32'h0)
    else $error("input word not zero");
  a_chan_word: assert property (s_rd_done ##0 (avs_address_i == 7'h44 && mode_o == rsch_mode_setup)
    |-> avs_readdata_o == {16'h0000, $past(channel_one_status_i)})
    else $error("channel one word wrong");
  a_save_pulse: assert property (nv_save_o |-> mode_o != rsch_mode_setup ##1 !nv_save_o)
    else $error("save pulse");
  a_saved_hold: assert property (!$past(rst_i) && !$stable({channel_one_fsc_o, channel_one_preset_o})
    |-> nv_save_o)
    else $error("saved set changed");
endmodule

bind rsch_top rsch_top_chk rsch_top_chk_i (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .channel_one_status_i,
  .mode_o, .module_status_o, .nv_save_o, .channel_one_fsc_o, .channel_one_preset_o);

// ### verif/rsch_host.sv
// Host model: Avalon-MM master sending commands, polling status.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/1ps
`include "rsch_cfg.svh"
module rsch_host (
  input  wire logic                clk_i,
  output logic [`RSCH_AW-1:0]      avs_address_o,
  output logic                     avs_read_o,
  output logic                     avs_write_o,
  output logic [31:0]              avs_writedata_o,
  output logic [3:0]               avs_byteenable_o,
  input  wire logic [31:0]         avs_readdata_i,
  input  wire logic                avs_waitrequest_i
);
  initial begin
    {avs_address_o, avs_read_o, avs_write_o, avs_writedata_o} = 41'h0;
    avs_byteenable_o = 4'hf;
  end

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    avs_address_o   <= a;
    avs_writedata_o <= {16'h0000, d};
    avs_write_o     <= 1'b1;
    @(posedge clk_i);
    while (avs_waitrequest_i) @(posedge clk_i);
    avs_write_o     <= 1'b0;
    // Released data shows no stale value
    avs_writedata_o <= ~{16'h0000, d};
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    avs_address_o <= a;
    avs_read_o    <= 1'b1;
    @(posedge clk_i);
    while (avs_waitrequest_i) @(posedge clk_i);
    d = avs_readdata_i;
    avs_read_o    <= 1'b0;
    @(posedge clk_i);
  endtask

  // Data words, then command, then transmit clear
  task automatic send(input logic [0:9][15:0] w, output logic [15:0] ack_st, output logic [15:0] clr_st);
    logic [31:0] d;
    int          n;
    for (int i = 1; i < 10; i++) begin
      wr({1'b0, i[3:0], 2'b00}, w[i]);
    end
    wr(7'h00, w[0]);
    d = 32'h0;
    for (n = 0; n < 40 && !d[15]; n++) rd(7'h40, d);
    ack_st = d[15:0];
    wr(7'h00, 16'h0000);
    for (n = 0; n < 40 && d[15]; n++) rd(7'h40, d);
    clr_st = d[15:0];
  endtask
endmodule

// ### verif/tb.sv
// Self-checking bench for the setup handler.
// Assumes host model and checker compiled first.
`timescale 1ns/1ps
`include "rsch_cfg.svh"
module tb
  import rsch_pkg::*;
;
  logic                clk_i;
  logic                rst_i;
  logic [`RSCH_AW-1:0] adr;
  logic                rd;
  logic                wr;
  logic [31:0]         wd;
  logic [3:0]          be;
  logic [31:0]         rdat;
  logic                wreq;
  logic [15:0]         st1;
  logic [15:0]         st2;
  rsch_mode_t          mode;
  rsch_kind_t          kind;
  logic [15:0]         mst;
  logic                nvs;
  logic [15:0]         s1;
  logic [15:0]         s2;
  logic [31:0]         f1;
  logic [31:0]         f2;
  logic [31:0]         p1;
  logic [31:0]         p2;
  logic [15:0]         dty;
  logic [15:0]         dtu;
  int                  n_fail = 0;
  int                  num_checks = 0;
  int                  n_save = 0;
  int                  cyc = 0;

  rsch_host rsch_host_i (.clk_i(clk_i), .avs_address_o(adr), .avs_read_o(rd), .avs_write_o(wr),
    .avs_writedata_o(wd), .avs_byteenable_o(be), .avs_readdata_i(rdat), .avs_waitrequest_i(wreq));

  rsch_top rsch_top_i (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .channel_one_status_i(st1), .channel_two_status_i(st2), .mode_o(mode),
    .module_status_o(mst), .nv_save_o(nvs), .param_kind_o(kind), .channel_one_setup_o(s1),
    .channel_one_fsc_o(f1), .channel_one_preset_o(p1), .channel_two_setup_o(s2),
    .channel_two_fsc_o(f2), .channel_two_preset_o(p2), .dual_type_o(dty), .dual_turns_o(dtu));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (nvs === 1'b1) n_save++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmd(input logic [0:9][15:0] w, input logic [3:0] e);
    logic [15:0] a;
    logic [15:0] c;
    rsch_host_i.send(w, a, c);
    chk("ack", 32'h1, {31'h0, a[15]});
    chk("err", {28'h0, e}, {28'h0, a[3:0]});
    chk("ack_clear", 32'h0, {31'h0, c[15]});
  endtask

  task automatic sgl(input logic [15:0] c, s, input logic [31:0] f, input logic [15:0] p, t,
                     input logic [31:0] g, input logic [15:0] q, r, input logic [3:0] e);
    cmd({c, s, f[15:0], f[31:16], p, t, g[15:0], g[31:16], q, r}, e);
  endtask

  task automatic dul(input logic [15:0] c, s, ty, tu, input logic [31:0] f, p,
                     input logic [15:0] r, input logic [3:0] e);
    cmd({c, s, ty, tu, f[15:0], f[31:16], p[15:0], p[31:16], r, 16'h0}, e);
  endtask

  task automatic chk_mode(input rsch_mode_t m);
    chk("mode", {30'h0, m}, {30'h0, mode});
  endtask

  task automatic t_idle();
    logic [31:0] d;
    rsch_host_i.rd(7'h40, d);
    chk("status", 32'h0, d);
    rsch_host_i.wr(7'h40, 16'hffff);
    rsch_host_i.rd(7'h40, d);
    chk("status_ro", 32'h0, d);
    rsch_host_i.rd(7'h28, d);
    chk("unmapped", 32'h0, d);
    chk_mode(rsch_mode_meas);
    chk("fsc_def", 32'h400, f1);
    chk("turns_def", 32'h1, {16'h0, dtu});
    $display("t_idle done");
  endtask

  task automatic t_enter();
    logic [31:0] d;
    sgl(16'hb011, 16'h0, 32'h400, 16'h0, 16'h0, 32'h400, 16'h0, 16'h0, 4'h1);
    cmd({16'hb000, 16'h1299, {8{16'h0}}}, 4'h1);
    cmd({16'hb000, 16'h1298, {8{16'h0}}}, 4'h0);
    rsch_host_i.rd(7'h40, d);
    chk("in_setup", 32'h1000, d);
    chk_mode(rsch_mode_setup);
    $display("t_enter done");
  endtask

  task automatic t_layout();
    logic [31:0] d;
    logic [31:0] e;
    st1 <= 16'h1234;
    st2 <= 16'habcd;
    @(posedge clk_i);
    for (int k = 0; k < 10; k++) begin
      rsch_host_i.rd({1'b1, k[3:0], 2'b00}, d);
      e = (k == 0) ? 32'h1000 : (k == 1) ? {16'h0, st1} : (k == 5) ? {16'h0, st2} : 32'h0;
      chk("input_word", e, d);
    end
    $display("t_layout done");
  endtask

  task automatic t_checks();
    sgl(16'hb011, 16'h3, 32'h10000, 16'hffff, 16'hffff, 32'h0, 16'hffff, 16'hffff, 4'h0);
    sgl(16'hb011, 16'h0, 32'h1, 16'h0, 16'h0, 32'h2, 16'h0, 16'h0, 4'h1);
    sgl(16'hb011, 16'h0, 32'h10001, 16'h0, 16'h0, 32'h2, 16'h0, 16'h0, 4'h1);
    sgl(16'hb011, 16'h0, 32'h10, 16'h10, 16'h0, 32'h2, 16'h0, 16'h0, 4'h1);
    sgl(16'hb011, 16'h4, 32'h10, 16'h0, 16'h0, 32'h2, 16'h0, 16'h0, 4'h1);
    sgl(16'hb021, 16'hffff, 32'h0, 16'hffff, 16'h0, 32'h2, 16'h1, 16'h0, 4'h0);
    sgl(16'hb021, 16'h0, 32'h2, 16'h0, 16'h0, 32'h2, 16'h1, 16'h1, 4'h1);
    sgl(16'hb031, 16'h0, 32'h2, 16'h1, 16'h0, 32'h0, 16'h0, 16'h0, 4'h1);
    dul(16'hb002, 16'h0, 16'h3e8, 16'ha, 32'ha0000, 32'h9ffff, 16'h0, 4'h0);
    dul(16'hb002, 16'h0, 16'h3e8, 16'ha, 32'ha0001, 32'h0, 16'h0, 4'h1);
    dul(16'hb002, 16'h0, 16'h3e8, 16'h5, 32'h400, 32'h0, 16'h0, 4'h1);
    dul(16'hb002, 16'h0, 16'hc8, 16'h1, 32'h400, 32'h0, 16'h0, 4'h1);
    dul(16'hb002, 16'h0, 16'h64, 16'h4, 32'h400, 32'h0, 16'h1, 4'h1);
    dul(16'hb004, 16'h0, 16'h81, 16'h1, 32'h400, 32'h0, 16'h0, 4'h1);
    dul(16'hb004, 16'h0, 16'hc, 16'h5, 32'h400, 32'h0, 16'h0, 4'h1);
    dul(16'hb004, 16'h100, 16'hc, 16'h6, 32'h2, 32'h1, 16'h0, 4'h0);
    dul(16'hb055, 16'h0, 16'hc, 16'h6, 32'h2, 32'h1, 16'h0, 4'h1);
    chk("fsc_kept", 32'h400, f1);
    cmd({16'h800f, {9{16'h0}}}, 4'h0);
    chk_mode(rsch_mode_meas);
    chk("fsc_old", 32'h400, f1);
    chk("no_save", 32'h0, n_save);
    $display("t_checks done");
  endtask

  task automatic t_save();
    cmd({16'hb000, 16'h1298, {8{16'h0}}}, 4'h0);
    sgl(16'hb031, 16'h3, 32'h10000, 16'hffff, 16'h1, 32'hc670, 16'h1234, 16'h0, 4'h0);
    cmd({16'h800e, {9{16'h0}}}, 4'h0);
    chk("saves", 32'h1, n_save);
    chk_mode(rsch_mode_meas);
    chk("s1", 32'h3, {16'h0, s1});
    chk("f1", 32'h10000, f1);
    chk("p1", 32'hffff, p1);
    chk("f2", 32'hc670, f2);
    chk("p2", 32'h1234, p2);
    cmd({16'hb000, 16'h1298, {8{16'h0}}}, 4'h0);
    dul(16'hb004, 16'h101, 16'h40, 16'h8, 32'h80000, 32'h7ffff, 16'h0, 4'h0);
    cmd({16'h800e, {9{16'h0}}}, 4'h0);
    chk_mode(rsch_mode_align);
    chk("kind", {30'h0, rsch_kind_foreign}, {30'h0, kind});
    chk("dual_fsc", 32'h80000, f1);
    chk("dual_pre", 32'h7ffff, p1);
    chk("dual_type", 32'h40, {16'h0, dty});
    chk("dual_turns", 32'h8, {16'h0, dtu});
    chk("s2", 32'h101, {16'h0, s2});
    $display("t_save done");
  endtask

  initial begin
    rst_i = 1'b1;
    st1 = 16'h0;
    st2 = 16'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_idle();
    t_enter();
    t_layout();
    t_checks();
    t_save();
    test_done();
  end
endmodule
